// ### hw/wdt_pd_defines.vh
`ifndef WDT_PD_DEFINES_VH
`define WDT_PD_DEFINES_VH
// register offsets
`define ADDR_WATCHDOG_CONTROL 4'h0
`define ADDR_RESET_CAUSE 4'h1
`define ADDR_MODE_CONTROL 4'h2
`define ADDR_STATUS 4'h3
`define ADDR_PORT_A_WAKE 4'h4
`define ADDR_COMMAND 4'h5
`define ADDR_WAKE_CAUSE 4'h6
// reset values and key codes
`define WATCHDOG_CONTROL_RESET 8'h53
`define KEY_DISABLE 5'h15
`define KEY_ENABLE 5'h0a
`define PERIOD_RESET 3'h3
// field positions
`define KEY_HI 7
`define KEY_LO 3
`define MODE_FAST_KEEP 0
`define MODE_SLOW_KEEP 1
`define MODE_SUB_SEL 2
`define STAT_PDF 0
`define STAT_TO 1
`define CMD_WATCHDOG_CLEAR_INSTRUCTION 0
`define CMD_HALT 1
// invalid key reset delay in slow-clock edges (2~3 taken as 2 full edges)
`define KEY_RESET_SLOW_EDGES 2'h2
// power modes
`define PM_RUN 3'h0
`define PM_SLEEP 3'h1
`define PM_IDLE0 3'h2
`define PM_IDLE1 3'h3
`define PM_FAST_ONLY 3'h4
`endif

// ### hw/wdt_power_down.v
`timescale 1ns/1ps
//Contract
// [R1] fast-only idle: fast on, slow stopped, halt
// [R2] keep bits pick sleep, idle0, idle1
// [R3] power-down entry sets pdf, clears to
// [R4] entry clears counter; counts only if enabled
// [R5] registers and ports held during power-down
// [R6] wake on reset, port a, interrupt, overflow
// [R7] external reset wake gives full reset
// [R8] pdf cleared by power-up or clear; set halt
// [R9] timeout in power-down sets flags, resets pc
// [R10] per-pin port a falling edge wake
// [R11] interrupt wake: pending if disabled/stack full
// [R12] flag set before entry cannot wake
// [R13] counter clocked by selected slow clock
// [R14] period select picks 2^8..2^18 tap
// [R15] bad key resets after slow cycles
// [R16] bad key reset sets key reset flag
// [R17] power-on key enable, period 011
// [R18] key reset flag cleared only by software
// [R19] normal overflow resets device, sets to
// [R20] counter cleared by key reset, clear, halt, pin
// [R21] software clears watchdog before overflow
// [R22] counter 18 bits, tap by period select
`include "wdt_pd_defines.vh"
module wdt_power_down #(
  parameter PORT_W = 8,
  parameter IRQ_W = 4,
  parameter CNT_W = 18
) (
  // clock and reset
  input wire mclk,
  input wire reset_n,
  // register port
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [7:0] rdata,
  // oscillators and pins
  input wire crystal_low_speed_osc,
  input wire internal_low_speed_osc,
  input wire external_clear_n,
  input wire [PORT_W-1:0] port_a_in,
  // interrupt sources from core
  input wire [IRQ_W-1:0] irq_req,
  input wire [IRQ_W-1:0] irq_en,
  input wire stack_full,
  // outputs to core
  output reg cpu_halt,
  output reg fast_clock_on,
  output reg slow_clock_on,
  output reg [2:0] power_mode,
  output reg full_reset,
  output reg pc_sp_reset,
  output reg irq_service,
  output reg wake_pulse
);
  reg rst_a_r, rst_b_r;
  wire rst_n = rst_b_r;
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_a_r <= 1'b0;
      rst_b_r <= 1'b0;
    end else begin
      rst_a_r <= 1'b1;
      rst_b_r <= rst_a_r;
    end
  end

  // pin synchronisers
  reg [PORT_W+3:0] sy1_r, sy2_r;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sy1_r <= {(PORT_W+4){1'b1}};
      sy2_r <= {(PORT_W+4){1'b1}};
    end else begin
      sy1_r <= {crystal_low_speed_osc, internal_low_speed_osc, external_clear_n, 1'b1, port_a_in};
      sy2_r <= sy1_r;
    end
  end
  wire [PORT_W-1:0] pa_s = sy2_r[PORT_W-1:0];
  wire clr_pin_n_s = sy2_r[PORT_W+1];
  wire internal_low_speed_osc_s = sy2_r[PORT_W+2];
  wire lxt_s = sy2_r[PORT_W+3];

  reg [7:0] watchdog_control_r;
  reg key_flag_r;
  reg fast_keep_r, slow_keep_r, sub_sel_r;
  reg pdf_r, to_r;
  reg [PORT_W-1:0] pa_wake_r, pa_prev_r;
  reg [IRQ_W-1:0] irq_mask_r;
  reg [2:0] pm_r;
  reg [CNT_W-1:0] cnt_r;
  reg slow_prev_r, internal_low_speed_osc_prev_r, clr_prev_r;
  reg [1:0] key_cnt_r;
  reg [2:0] wake_cause_r;

  wire [4:0] key = watchdog_control_r[`KEY_HI:`KEY_LO];
  wire key_ok = (key == `KEY_ENABLE) || (key == `KEY_DISABLE);
  wire wdt_en = (key == `KEY_ENABLE);
  // slow clock pick and rising edge
  wire slow_s = sub_sel_r ? lxt_s : internal_low_speed_osc_s; // [R13]
  wire slow_rise = slow_s & ~slow_prev_r;
  wire internal_low_speed_osc_rise = internal_low_speed_osc_s & ~internal_low_speed_osc_prev_r;
  // slow clock stops in sleep and fast-only idle
  wire slow_run = (pm_r == `PM_RUN) || (pm_r == `PM_IDLE0) || (pm_r == `PM_IDLE1); // [R1]

  // tap select
  reg [4:0] tap;
  always @* begin
    case (watchdog_control_r[2:0]) // [R14]
      3'h0: tap = 5'd8;
      3'h1: tap = 5'd10;
      3'h2: tap = 5'd12;
      3'h3: tap = 5'd14;
      3'h4: tap = 5'd15;
      3'h5: tap = 5'd16;
      3'h6: tap = 5'd17;
      default: tap = 5'd18;
    endcase
  end
  wire [CNT_W-1:0] limit = {{(CNT_W-1){1'b0}}, 1'b1} << tap;
  wire overflow = wdt_en && slow_rise && slow_run && (cnt_r == limit - 1'b1); // [R22]

  wire wr_cmd = wr_stb && (addr == `ADDR_COMMAND);
  wire clr_cmd = wr_cmd && wdata[`CMD_WATCHDOG_CLEAR_INSTRUCTION];
  wire halt_cmd = wr_cmd && wdata[`CMD_HALT] && (pm_r == `PM_RUN);
  wire key_reset = !key_ok && (key_cnt_r == `KEY_RESET_SLOW_EDGES); // [R15]
  wire pd = (pm_r != `PM_RUN);

  // wake events
  wire [PORT_W-1:0] pa_fall = pa_prev_r & ~pa_s & pa_wake_r; // [R10]
  wire [IRQ_W-1:0] irq_wake = irq_req & ~irq_mask_r; // [R12]
  wire pa_wake = pd && (|pa_fall);
  wire irq_wk = pd && (|irq_wake);
  wire ext_clr = !clr_pin_n_s;

  reg [2:0] pm_nxt;
  always @* begin
    if (fast_keep_r && slow_keep_r)
      pm_nxt = `PM_IDLE1; // [R2]
    else if (fast_keep_r)
      pm_nxt = `PM_FAST_ONLY; // [R1]
    else if (slow_keep_r)
      pm_nxt = `PM_IDLE0;
    else
      pm_nxt = `PM_SLEEP;
  end

  // slow edge history, reset to the synchroniser idle level so no false edge follows
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      slow_prev_r <= 1'b1;
      internal_low_speed_osc_prev_r <= 1'b1;
    end else begin
      slow_prev_r <= slow_s;
      internal_low_speed_osc_prev_r <= internal_low_speed_osc_s;
    end
  end

  // pin edge history, idle high
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pa_prev_r <= {PORT_W{1'b1}};
      clr_prev_r <= 1'b1;
    end else begin
      pa_prev_r <= pa_s;
      clr_prev_r <= clr_pin_n_s;
    end
  end

  // one event per cycle: reset, overflow, halt, port wake, interrupt wake, clear
  wire ext_fall = clr_prev_r & ~clr_pin_n_s; // [R7]
  wire rst_evt = ext_fall || key_reset;
  wire ovf_go = !rst_evt && overflow;
  wire busy_go = rst_evt || overflow;
  wire halt_go = !busy_go && halt_cmd;
  wire pa_go = !busy_go && !halt_cmd && pa_wake; // [R10]
  wire irq_go = !busy_go && !halt_cmd && !pa_wake && irq_wk; // [R11]
  wire clr_go = !busy_go && !halt_cmd && !pa_wake && !irq_wk && clr_cmd; // [R8]
  wire pd_wdt = ovf_go && pd; // [R9]
  wire run_wdt = ovf_go && !pd; // [R19]

  // bad key delay counted on the low-speed oscillator
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      key_cnt_r <= 2'h0;
    end else if (key_ok || key_reset) begin
      key_cnt_r <= 2'h0;
    end else if (internal_low_speed_osc_rise) begin
      key_cnt_r <= key_cnt_r + 2'h1; // [R15]
    end
  end

  // watchdog control; a bad key brings back the power-on value
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_control_r <= `WATCHDOG_CONTROL_RESET; // [R17]
    end else if (key_reset) begin
      watchdog_control_r <= `WATCHDOG_CONTROL_RESET; // [R15]
    end else if (wr_stb && !pd && addr == `ADDR_WATCHDOG_CONTROL) begin
      watchdog_control_r <= wdata; // [R5]
    end
  end

  // idle keep bits and sub clock select
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fast_keep_r <= 1'b0;
      slow_keep_r <= 1'b0;
      sub_sel_r <= 1'b0;
    end else if (wr_stb && !pd && addr == `ADDR_MODE_CONTROL) begin
      fast_keep_r <= wdata[`MODE_FAST_KEEP];
      slow_keep_r <= wdata[`MODE_SLOW_KEEP];
      sub_sel_r <= wdata[`MODE_SUB_SEL]; // [R13]
    end
  end

  // port a wake enables, one bit per pin
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pa_wake_r <= {PORT_W{1'b0}};
    end else if (wr_stb && !pd && addr == `ADDR_PORT_A_WAKE) begin
      pa_wake_r <= wdata[PORT_W-1:0]; // [R10]
    end
  end

  // key reset flag: set wins, only software zero clears
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      key_flag_r <= 1'b0;
    end else if (key_reset) begin
      key_flag_r <= 1'b1; // [R16]
    end else if (wr_stb && addr == `ADDR_RESET_CAUSE && !wdata[0]) begin
      key_flag_r <= 1'b0; // [R18]
    end
  end

  // watchdog counter; held at zero while disabled
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= {CNT_W{1'b0}};
    end else if (key_reset || clr_cmd || halt_cmd || ext_clr || overflow || !wdt_en) begin
      cnt_r <= {CNT_W{1'b0}}; // [R20] [R4]
    end else if (slow_rise && slow_run) begin
      cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1}; // [R13]
    end
  end

  // power state
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pm_r <= `PM_RUN;
    end else if (rst_evt || pd_wdt || pa_go || irq_go) begin
      pm_r <= `PM_RUN; // [R6] [R7]
    end else if (halt_go) begin
      pm_r <= pm_nxt; // [R2] [R1]
    end
  end

  // power-down flag
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pdf_r <= 1'b0; // [R8]
    end else if (pd_wdt || halt_go) begin
      pdf_r <= 1'b1; // [R3] [R9]
    end else if (clr_go) begin
      pdf_r <= 1'b0; // [R8]
    end
  end

  // watchdog expiry flag
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      to_r <= 1'b0;
    end else if (ovf_go) begin
      to_r <= 1'b1; // [R19] [R9]
    end else if (halt_go || clr_go) begin
      to_r <= 1'b0; // [R3]
    end
  end

  // requests already pending at halt may not wake
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_r <= {IRQ_W{1'b0}};
    end else if (halt_go) begin
      irq_mask_r <= irq_req; // [R12]
    end
  end

  // last wake source
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wake_cause_r <= 3'h0;
    end else if (rst_evt && pd) begin
      wake_cause_r <= 3'h1;
    end else if (pd_wdt) begin
      wake_cause_r <= 3'h4;
    end else if (pa_go) begin
      wake_cause_r <= 3'h2;
    end else if (irq_go) begin
      wake_cause_r <= 3'h3;
    end
  end

  // reset pulses, one cycle per event even while the pin stays low
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      full_reset <= 1'b0;
      pc_sp_reset <= 1'b0;
    end else begin
      full_reset <= rst_evt || run_wdt; // [R7] [R19]
      pc_sp_reset <= pd_wdt; // [R9]
    end
  end

  // wake and interrupt pulses
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_service <= 1'b0;
      wake_pulse <= 1'b0;
    end else begin
      irq_service <= irq_go && (|(irq_wake & irq_en)) && !stack_full; // [R11]
      wake_pulse <= (rst_evt && pd) || pd_wdt || pa_go || irq_go; // [R6]
    end
  end

  // halt and mode levels, one cycle behind the power state
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_halt <= 1'b0;
      power_mode <= `PM_RUN;
    end else begin
      cpu_halt <= pd; // [R1]
      power_mode <= pm_r;
    end
  end

  // clock enables
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fast_clock_on <= 1'b1;
      slow_clock_on <= 1'b1;
    end else begin
      fast_clock_on <= (pm_r == `PM_RUN) || (pm_r == `PM_IDLE1) || (pm_r == `PM_FAST_ONLY);
      slow_clock_on <= slow_run; // [R1]
    end
  end

  // read mux; data stands only in the cycle after the strobe
  reg [7:0] rdata_nxt;
  always @* begin
    rdata_nxt = 8'h00;
    if (rd_stb) begin
      case (addr)
        `ADDR_WATCHDOG_CONTROL: rdata_nxt = watchdog_control_r;
        `ADDR_RESET_CAUSE: rdata_nxt = {7'h00, key_flag_r};
        `ADDR_MODE_CONTROL: rdata_nxt = {5'h00, sub_sel_r, slow_keep_r, fast_keep_r};
        `ADDR_STATUS: rdata_nxt = {6'h00, to_r, pdf_r};
        `ADDR_PORT_A_WAKE: rdata_nxt = pa_wake_r;
        `ADDR_WAKE_CAUSE: rdata_nxt = {5'h00, wake_cause_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rdata_nxt;
    end
  end
endmodule // wdt_power_down

// ### verif/wdt_pd_asserts.sv
`timescale 1ns/1ps
module wdt_pd_asserts (
  // clock, reset and bus
  input logic mclk,
  input logic reset_n,
  input logic [3:0] addr,
  input logic [7:0] wdata,
  input logic wr_stb,
  // pins and core inputs
  input logic external_clear_n,
  input logic stack_full,
  input logic [3:0] irq_en,
  // core outputs
  input logic cpu_halt,
  input logic fast_clock_on,
  input logic slow_clock_on,
  input logic [2:0] power_mode,
  input logic full_reset,
  input logic pc_sp_reset,
  input logic irq_service,
  input logic wake_pulse
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  fast_only_clk_a: assert property (power_mode == 3'h4 |-> fast_clock_on && !slow_clock_on)
    else $error("fast-only idle clocks wrong");
  idle0_clk_a: assert property (power_mode == 3'h2 |-> !fast_clock_on && slow_clock_on)
    else $error("idle0 clocks wrong");
  idle1_clk_a: assert property (power_mode == 3'h3 |-> fast_clock_on && slow_clock_on)
    else $error("idle1 clocks wrong");
  halt_entry_a: assert property (wr_stb && addr == 4'h5 && wdata[1] && power_mode == 3'h0
    |-> ##2 cpu_halt) else $error("halt not entered");
  wake_run_a: assert property (wake_pulse |-> ##[0:3] power_mode == 3'h0)
    else $error("wake did not return to run");
  wake_halted_a: assert property (wake_pulse |-> cpu_halt)
    else $error("wake while running");
  pc_reset_halt_a: assert property (pc_sp_reset |-> cpu_halt)
    else $error("pc reset outside power-down");
  irq_service_a: assert property (irq_service |-> !$past(stack_full) && $past(irq_en) != 4'h0)
    else $error("interrupt serviced wrongly");
  reset_pulse_a: assert property (full_reset |=> !full_reset)
    else $error("full reset longer than one cycle");
  clear_pin_a: assert property ($fell(external_clear_n) |-> ##[1:6] full_reset)
    else $error("clear pin gave no reset");
  cover property (power_mode == 3'h4);
  cover property (pc_sp_reset);
  cover property (irq_service);
  cover property (full_reset);
endmodule // wdt_pd_asserts

bind wdt_power_down wdt_pd_asserts chk (.mclk, .reset_n, .addr, .wdata, .wr_stb,
  .external_clear_n, .stack_full, .irq_en, .cpu_halt, .fast_clock_on, .slow_clock_on,
  .power_mode, .full_reset, .pc_sp_reset, .irq_service, .wake_pulse);

// ### verif/watchdog_power_down_wakeup_bench.sv
`timescale 1ns/1ps
module watchdog_power_down_wakeup_bench;
  logic mclk = 0, reset_n = 0, wr_stb = 0, rd_stb = 0, stack_full = 0, external_clear_n = 1;
  logic [3:0] addr = 4'h0, irq_req = 4'h0, irq_en = 4'h0, dv = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, port_a_in = 8'hff, v;
  logic cpu_halt, fast_clock_on, slow_clock_on, full_reset, pc_sp_reset, irq_service, wake_pulse;
  logic [2:0] power_mode;
  logic [2:0] em [4] = '{3'h1, 3'h4, 3'h2, 3'h3};
  logic h;
  int mismatches = 0, cmp_count = 0;
  always #5 mclk = ~mclk;
  // slow oscillators, well below the sampling limit
  always @(posedge mclk) dv <= dv + 4'h1;
  wdt_power_down dut (.mclk(mclk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .crystal_low_speed_osc(dv[3]),
    .internal_low_speed_osc(dv[2]), .external_clear_n(external_clear_n),
    .port_a_in(port_a_in), .irq_req(irq_req), .irq_en(irq_en), .stack_full(stack_full),
    .cpu_halt(cpu_halt), .fast_clock_on(fast_clock_on), .slow_clock_on(slow_clock_on),
    .power_mode(power_mode), .full_reset(full_reset), .pc_sp_reset(pc_sp_reset),
    .irq_service(irq_service), .wake_pulse(wake_pulse));
  task finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask
  // waits for full reset, pc reset, irq service or run mode
  task wsig(input int s, input int lim, output logic f);
    int n;
    f = 1'b0;
    for (n = 0; n < lim && f !== 1'b1; n++) begin
      @(posedge mclk);
      #1;
      case (s)
        0: f = full_reset;
        1: f = pc_sp_reset;
        2: f = irq_service;
        default: f = (power_mode == 3'h0);
      endcase
    end
  endtask
  initial begin
    #300000;
    mismatches++;
    finish_test;
  end
  initial begin
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(4'h0, v); chk(v, 8'h53);
    rd(4'h1, v); chk(v, 8'h00);
    rd(4'h3, v); chk(v, 8'h00);
    wr(4'h4, 8'h01);
    for (int m = 0; m < 4; m++) begin
      wr(4'h2, m[7:0]);
      wr(4'h5, 8'h02);
      repeat (3) @(posedge mclk);
      #1 chk({5'h0, power_mode}, {5'h0, em[m]});
      rd(4'h3, v); chk(v, 8'h01);
      port_a_in[1] <= 1'b0;
      wsig(3, 12, h); chk({7'h0, h}, 8'h00);
      port_a_in <= 8'hfe;
      wsig(3, 12, h); chk({7'h0, h}, 8'h01);
      port_a_in <= 8'hff;
      repeat (4) @(posedge mclk);
    end
    wr(4'h5, 8'h01);
    rd(4'h3, v); chk(v, 8'h00);
    wr(4'h0, 8'h50);
    wsig(0, 3000, h); chk({7'h0, h}, 8'h01);
    rd(4'h3, v); chk(v & 8'h02, 8'h02);
    wr(4'h2, 8'h02);
    wr(4'h0, 8'h50);
    wr(4'h5, 8'h02);
    wsig(1, 3000, h); chk({7'h0, h}, 8'h01);
    rd(4'h3, v); chk(v, 8'h03);
    wr(4'h0, 8'ha8);
    wr(4'h5, 8'h02);
    wsig(1, 2600, h); chk({7'h0, h}, 8'h00);
    port_a_in <= 8'hfe;
    wsig(3, 12, h); chk({7'h0, h}, 8'h01);
    port_a_in <= 8'hff;
    irq_en <= 4'hf;
    wr(4'h5, 8'h02);
    repeat (3) @(posedge mclk);
    irq_req <= 4'h1;
    wsig(2, 20, h); chk({7'h0, h}, 8'h01);
    wr(4'h5, 8'h02);
    repeat (2) @(posedge mclk);
    wsig(3, 20, h); chk({7'h0, h}, 8'h00);
    stack_full <= 1'b1;
    irq_req <= 4'h3;
    wsig(2, 20, h); chk({7'h0, h}, 8'h00);
    chk({5'h0, power_mode}, 8'h00);
    irq_req <= 4'h0;
    stack_full <= 1'b0;
    wr(4'h0, 8'h00);
    wsig(0, 100, h); chk({7'h0, h}, 8'h01);
    rd(4'h1, v); chk(v, 8'h01);
    rd(4'h0, v); chk(v, 8'h53);
    wr(4'h1, 8'h00);
    rd(4'h1, v); chk(v, 8'h00);
    wr(4'h2, 8'h04);
    wr(4'h0, 8'h50);
    wsig(0, 3000, h); chk({7'h0, h}, 8'h00);
    wsig(0, 1500, h); chk({7'h0, h}, 8'h01);
    external_clear_n <= 1'b0;
    wsig(0, 20, h); chk({7'h0, h}, 8'h01);
    external_clear_n <= 1'b1;
    repeat (5) @(posedge mclk);
    finish_test;
  end
endmodule // watchdog_power_down_wakeup_bench
